/* File: src/cac_counter_array.sv */
// Our own choices: strobed register access and the address map.
`default_nettype none
module cac_counter_array
    import cac_pkg::*;
#(
    parameter int NUM_MOD = CAC_NUM_MOD
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire cac_bus_req_type bus_in,
    output logic [CAC_DW-1:0] rdata_out,
    // Processor context, same clock
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    input wire logic cpu_idle_in,
    input wire logic timer0_ovf_in,
    // Asynchronous pins
    input wire logic ext_count_input_in,
    input wire logic ext_osc_in,
    input wire logic [NUM_MOD-1:0] module_pin_in,
    output logic [NUM_MOD-1:0] module_pin_out,
    output logic [NUM_MOD-1:0] module_pin_oe_out,
    // Interrupt request
    output logic irq_out
);
    logic [15:0] cnt_r;
    logic [7:0] snap_hi_r;
    logic [7:0] mode_r;
    logic ovf_flag_r;
    logic run_r;
    logic [NUM_MOD-1:0] match_flag_r;
    logic [7:0] mmode_r [NUM_MOD];
    logic [7:0] cmp_lo_r [NUM_MOD];
    logic [7:0] cmp_hi_r [NUM_MOD];
    logic [3:0] div12_r;
    logic [1:0] div4_r;
    logic [2:0] div8_r;
    logic [2:0] eci_sync_r;
    logic [2:0] osc_sync_r;
    logic [NUM_MOD-1:0] pin_s1_r;
    logic [NUM_MOD-1:0] pin_s2_r;
    logic [NUM_MOD-1:0] pin_s3_r;
    logic upd_r;
    logic [NUM_MOD-1:0] pin_r;
    logic [NUM_MOD-1:0] oe_r;
    logic [CAC_DW-1:0] rdata_r;
    logic irq_r;

    logic wdt_on;
    logic tick;
    logic adv;
    logic cnt_wrap;
    logic osc_rise;
    logic [2:0] tb_sel;
    cac_mode_type mdec [NUM_MOD];
    logic [NUM_MOD-1:0] cap_hit;
    logic [NUM_MOD-1:0] full_hit;
    logic [NUM_MOD-1:0] low_hit;
    logic [NUM_MOD-1:0] flag_set;

    assign wdt_on = mode_r[CAC_MD_WDT_EN];
    assign tb_sel = mode_r[CAC_MD_TB_LSB +: 3];

    // Pins pass two flops; the third stage only serves edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Edge stages reset to each pin's idle level, so no false edge follows
            eci_sync_r <= 3'h7;
            osc_sync_r <= 3'h0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            eci_sync_r <= {eci_sync_r[1:0], ext_count_input_in};
            osc_sync_r <= {osc_sync_r[1:0], ext_osc_in};
            pin_s1_r <= module_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    assign osc_rise = osc_sync_r[1] && !osc_sync_r[2];

    // Prescalers run freely so a timebase change takes effect at once
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div12_r <= 4'h0;
            div4_r <= 2'h0;
            div8_r <= 3'h0;
        end else begin
            div12_r <= (div12_r == CAC_DIV_SLOW - 4'h1) ? 4'h0 : div12_r + 4'h1;
            // Wraps on its own width, giving one tick in four
            div4_r <= div4_r + 2'h1;
            if (osc_rise) begin
                div8_r <= div8_r + 3'h1;
            end
        end
    end

    always_comb begin
        case (tb_sel)
            CAC_TB_SYS12: tick = (div12_r == CAC_DIV_SLOW - 4'h1);
            CAC_TB_SYS4: tick = (div4_r == CAC_DIV_FAST_LAST);
            CAC_TB_T0OVF: tick = timer0_ovf_in;
            // falling edges of external count input
            CAC_TB_EXTCNT: tick = eci_sync_r[2] && !eci_sync_r[1];
            CAC_TB_SYS: tick = 1'b1;
            CAC_TB_OSC8: tick = osc_rise && (div8_r == CAC_DIV_OSC_LAST);
            default: tick = 1'b0;
        endcase
    end

    // idle halts counting only when idle suspend is set
    assign adv = tick && (run_r || wdt_on) && !(cpu_idle_in && mode_r[CAC_MD_IDLE_SUSP]);
    assign cnt_wrap = adv && (cnt_r == 16'hffff);

    always_comb begin
        for (int i = 0; i < NUM_MOD; i++) begin
            // mode bits decoded to one mode
            mdec[i] = cac_decode(mmode_r[i]);
            cap_hit[i] = (mdec[i] == CAC_M_CAPTURE) &&
                ((mmode_r[i][CAC_MM_CAP_RISE] && pin_s2_r[i] && !pin_s3_r[i]) ||
                 (mmode_r[i][CAC_MM_CAP_FALL] && !pin_s2_r[i] && pin_s3_r[i]));
            // compared once per new counter value
            full_hit[i] = upd_r && (cnt_r == {cmp_hi_r[i], cmp_lo_r[i]});
            low_hit[i] = upd_r && (cnt_r[7:0] == cmp_lo_r[i]);
            flag_set[i] = cap_hit[i] ||
                (full_hit[i] && (mdec[i] == CAC_M_SWTIMER || mdec[i] == CAC_M_HSO));
        end
    end

    // counter increments by one per event; reads never touch it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 16'h0000;
            upd_r <= 1'b0;
        end else begin
            // Marks a fresh count so a stopped counter cannot match again
            upd_r <= adv;
            // A software write wins over a count in the same cycle
            if (bus_in.wr && !wdt_on && bus_in.addr == CAC_ADDR_CNT_LO) begin
                cnt_r[7:0] <= bus_in.wdata;
            end else if (bus_in.wr && !wdt_on && bus_in.addr == CAC_ADDR_CNT_HI) begin
                cnt_r[15:8] <= bus_in.wdata;
            end else if (adv) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // snapshot of high byte on low-byte read
    // The low byte may roll over between the two reads; the copy hides that
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            snap_hi_r <= 8'h00;
        end else if (bus_in.rd && bus_in.addr == CAC_ADDR_CNT_LO) begin
            snap_hi_r <= cnt_r[15:8];
        end
    end

    // watchdog enabled from reset freezes timebase and idle control
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_r <= CAC_MODE_RST;
        end else if (bus_in.wr && bus_in.addr == CAC_ADDR_MODE) begin
            if (wdt_on) begin
                // Timebase and idle control stay frozen while the watchdog runs
                mode_r[CAC_MD_WDT_EN] <= bus_in.wdata[CAC_MD_WDT_EN];
                mode_r[CAC_MD_OVF_IE] <= bus_in.wdata[CAC_MD_OVF_IE];
            end else begin
                mode_r <= bus_in.wdata;
            end
        end
    end

    // Control bits and sticky flags; a hardware set beats a software clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            match_flag_r <= '0;
        end else begin
            if (bus_in.wr && bus_in.addr == CAC_ADDR_CTRL) begin
                // The watchdog forces counting without changing the run bit
                run_r <= bus_in.wdata[CAC_CT_RUN];
            end
            // wrap sets flag; only software clears
            if (cnt_wrap) begin
                ovf_flag_r <= 1'b1;
            end else if (bus_in.wr && bus_in.addr == CAC_ADDR_CTRL) begin
                ovf_flag_r <= bus_in.wdata[CAC_CT_OVF];
            end
            for (int i = 0; i < NUM_MOD; i++) begin
                // sticky match flag
                // Writing a one sets a flag, so software can raise a request
                if (flag_set[i]) begin
                    match_flag_r[i] <= 1'b1;
                end else if (bus_in.wr && bus_in.addr == CAC_ADDR_CTRL) begin
                    match_flag_r[i] <= bus_in.wdata[i];
                end
            end
        end
    end

    // Module mode registers; module 2 mode writes blocked while watchdog runs, compare writes still clear or set its enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_MOD; i++) begin
                mmode_r[i] <= CAC_MMODE_RST;
            end
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (bus_in.wr && bus_in.addr == CAC_ADDR_MMODE0 + CAC_AW'(i) &&
                    !(wdt_on && i == CAC_WDT_MOD)) begin
                    mmode_r[i] <= bus_in.wdata;
                // low write clears, high write sets compare enable
                end else if (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_LO0 + CAC_AW'(i)) begin
                    mmode_r[i][CAC_MM_CMP_EN] <= 1'b0;
                end else if (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_HI0 + CAC_AW'(i)) begin
                    mmode_r[i][CAC_MM_CMP_EN] <= 1'b1;
                end
            end
        end
    end

    // Compare registers; a software write overrides a capture in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_MOD; i++) begin
                cmp_lo_r[i] <= 8'h00;
                cmp_hi_r[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_LO0 + CAC_AW'(i)) begin
                    cmp_lo_r[i] <= bus_in.wdata;
                end else if (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_HI0 + CAC_AW'(i)) begin
                    cmp_hi_r[i] <= bus_in.wdata;
                end else if (cap_hit[i]) begin
                    cmp_lo_r[i] <= cnt_r[7:0];
                    cmp_hi_r[i] <= cnt_r[15:8];
                // next match point; zero step wraps by 256
                end else if (mdec[i] == CAC_M_FREQ && low_hit[i]) begin
                    // Eight-bit sum wraps, so the match point rolls with the low byte
                    cmp_lo_r[i] <= cmp_lo_r[i] + cmp_hi_r[i];
                end
            end
        end
    end

    // Output pins; level held between matches
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_r <= '0;
            oe_r <= '0;
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                // PWM modes are not built, so their pin stays undriven
                oe_r[i] <= (mdec[i] == CAC_M_HSO) || (mdec[i] == CAC_M_FREQ);
                if (mdec[i] == CAC_M_HSO && full_hit[i]) begin
                    pin_r[i] <= !pin_r[i];
                end else if (mdec[i] == CAC_M_FREQ && low_hit[i]) begin
                    pin_r[i] <= !pin_r[i];
                end
            end
        end
    end

    // Read port: data stands in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= 8'h00;
        end else if (!bus_in.rd) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= 8'h00;
            case (bus_in.addr)
                CAC_ADDR_CNT_LO: rdata_r <= cnt_r[7:0];
                CAC_ADDR_CNT_HI: rdata_r <= snap_hi_r;
                CAC_ADDR_MODE: rdata_r <= mode_r;
                CAC_ADDR_CTRL: begin
                    rdata_r[CAC_CT_OVF] <= ovf_flag_r;
                    rdata_r[CAC_CT_RUN] <= run_r;
                    rdata_r[NUM_MOD-1:0] <= match_flag_r;
                end
                CAC_ADDR_PINS: rdata_r[NUM_MOD-1:0] <= pin_s2_r;
                // Module registers; unmapped addresses read as zero
                default: begin
                    for (int i = 0; i < NUM_MOD; i++) begin
                        if (bus_in.addr == CAC_ADDR_MMODE0 + CAC_AW'(i)) begin
                            rdata_r <= mmode_r[i];
                        end
                        if (bus_in.addr == CAC_ADDR_CMP_LO0 + CAC_AW'(i)) begin
                            rdata_r <= cmp_lo_r[i];
                        end
                        if (bus_in.addr == CAC_ADDR_CMP_HI0 + CAC_AW'(i)) begin
                            rdata_r <= cmp_hi_r[i];
                        end
                    end
                end
            endcase
        end
    end

    // Interrupt request from registered flags
    // A level: it drops one cycle after the flag or an enable clears
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= 1'b0;
            if (global_irq_enable_in && array_irq_enable_in) begin
                if (ovf_flag_r && mode_r[CAC_MD_OVF_IE]) begin
                    irq_r <= 1'b1;
                end
                for (int i = 0; i < NUM_MOD; i++) begin
                    if (match_flag_r[i] && mmode_r[i][CAC_MM_IRQ_EN]) begin
                        irq_r <= 1'b1;
                    end
                end
            end
        end
    end

    assign rdata_out = rdata_r;
    assign module_pin_out = pin_r;
    assign module_pin_oe_out = oe_r;
    assign irq_out = irq_r;
endmodule : cac_counter_array
`default_nettype wire

/* File: src/cac_pkg.sv */
`default_nettype none
package cac_pkg;
    localparam int CAC_NUM_MOD = 3;
    localparam int CAC_AW = 4;
    localparam int CAC_DW = 8;

    // Register bus request, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [CAC_AW-1:0] addr;
        logic [CAC_DW-1:0] wdata;
    } cac_bus_req_type;

    // Register addresses
    localparam logic [CAC_AW-1:0] CAC_ADDR_CNT_LO = 4'h0;
    localparam logic [CAC_AW-1:0] CAC_ADDR_CNT_HI = 4'h1;
    localparam logic [CAC_AW-1:0] CAC_ADDR_MODE = 4'h2;
    localparam logic [CAC_AW-1:0] CAC_ADDR_CTRL = 4'h3;
    localparam logic [CAC_AW-1:0] CAC_ADDR_MMODE0 = 4'h4;
    localparam logic [CAC_AW-1:0] CAC_ADDR_PINS = 4'h7;
    localparam logic [CAC_AW-1:0] CAC_ADDR_CMP_LO0 = 4'h8;
    localparam logic [CAC_AW-1:0] CAC_ADDR_CMP_HI0 = 4'hc;

    // counter_mode_reg fields
    localparam int CAC_MD_IDLE_SUSP = 7;
    localparam int CAC_MD_WDT_EN = 6;
    localparam int CAC_MD_TB_LSB = 1;
    localparam int CAC_MD_OVF_IE = 0;
    localparam logic [7:0] CAC_MODE_RST = 8'h40;

    // array_control_reg fields (match flags sit in bits 2:0)
    localparam int CAC_CT_OVF = 7;
    localparam int CAC_CT_RUN = 6;

    // module_mode_reg fields
    localparam int CAC_MM_PWM16 = 7;
    localparam int CAC_MM_CMP_EN = 6;
    localparam int CAC_MM_CAP_RISE = 5;
    localparam int CAC_MM_CAP_FALL = 4;
    localparam int CAC_MM_MATCH = 3;
    localparam int CAC_MM_TOGGLE = 2;
    localparam int CAC_MM_PWM = 1;
    localparam int CAC_MM_IRQ_EN = 0;
    localparam logic [7:0] CAC_MMODE_RST = 8'h00;
    localparam int CAC_WDT_MOD = 2;

    // Timebase selections
    localparam logic [2:0] CAC_TB_SYS12 = 3'h0;
    localparam logic [2:0] CAC_TB_SYS4 = 3'h1;
    localparam logic [2:0] CAC_TB_T0OVF = 3'h2;
    localparam logic [2:0] CAC_TB_EXTCNT = 3'h3;
    localparam logic [2:0] CAC_TB_SYS = 3'h4;
    localparam logic [2:0] CAC_TB_OSC8 = 3'h5;

    // Divider counts
    localparam logic [3:0] CAC_DIV_SLOW = 4'hc;
    localparam logic [1:0] CAC_DIV_FAST_LAST = 2'h3;
    localparam logic [2:0] CAC_DIV_OSC_LAST = 3'h7;

    typedef enum {
        CAC_M_OFF,
        CAC_M_CAPTURE,
        CAC_M_SWTIMER,
        CAC_M_HSO,
        CAC_M_FREQ,
        CAC_M_PWM8,
        CAC_M_PWM16
    } cac_mode_type;

    function automatic cac_mode_type cac_decode(input logic [7:0] m);
        cac_mode_type r;
        r = CAC_M_OFF;
        if ((m[CAC_MM_CAP_RISE] || m[CAC_MM_CAP_FALL]) && !m[CAC_MM_MATCH] &&
            !m[CAC_MM_TOGGLE] && !m[CAC_MM_PWM]) begin
            r = CAC_M_CAPTURE;
        end else if (m[CAC_MM_CMP_EN] && !m[CAC_MM_CAP_RISE] && !m[CAC_MM_CAP_FALL]) begin
            if (m[CAC_MM_TOGGLE] && m[CAC_MM_PWM]) begin
                r = CAC_M_FREQ;
            end else if (m[CAC_MM_PWM]) begin
                r = m[CAC_MM_PWM16] ? CAC_M_PWM16 : CAC_M_PWM8;
            end else if (m[CAC_MM_MATCH] && m[CAC_MM_TOGGLE]) begin
                r = CAC_M_HSO;
            end else if (m[CAC_MM_MATCH]) begin
                r = CAC_M_SWTIMER;
            end
        end
        return r;
    endfunction : cac_decode
endpackage : cac_pkg
`default_nettype wire

/* File: tb/cac_counter_array_monitor.sv */
`default_nettype none
module cac_counter_array_monitor
    import cac_pkg::*;
#(
    parameter int NUM_MOD = CAC_NUM_MOD
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire cac_bus_req_type bus_in,
    input wire logic [CAC_DW-1:0] rdata_out,
    // Enables and request
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    input wire logic irq_out,
    // Pins
    input wire logic [NUM_MOD-1:0] module_pin_in,
    input wire logic [NUM_MOD-1:0] module_pin_out,
    input wire logic [NUM_MOD-1:0] module_pin_oe_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero outside answer");
    chk_irq_gate: assert property (
        irq_out |-> $past(global_irq_enable_in && array_irq_enable_in))
        else $error("request without both enables");
    chk_unmapped_rd: assert property (
        bus_in.rd && bus_in.addr inside {4'hb, 4'hf} |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_cmp_lo_clr: assert property (
        (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_LO0 + 4'h1) ##[1:2]
        (bus_in.rd && bus_in.addr == CAC_ADDR_MMODE0 + 4'h1) |=> !rdata_out[CAC_MM_CMP_EN])
        else $error("low write left compare enabled");
    chk_cmp_hi_set: assert property (
        (bus_in.wr && bus_in.addr == CAC_ADDR_CMP_HI0 + 4'h1) ##[1:2]
        (bus_in.rd && bus_in.addr == CAC_ADDR_MMODE0 + 4'h1) |=> rdata_out[CAC_MM_CMP_EN])
        else $error("high write left compare disabled");
    chk_pin_live: assert property (
        $stable(module_pin_in)[*4] ##0 (bus_in.rd && bus_in.addr == CAC_ADDR_PINS)
        |=> rdata_out[NUM_MOD-1:0] == $past(module_pin_in))
        else $error("pin level read wrong");
    chk_pin_hold: assert property (
        ((module_pin_out ^ $past(module_pin_out)) & ~module_pin_oe_out) == '0)
        else $error("pin output moved while not driven");
    chk_oe_cause: assert property ($changed(module_pin_oe_out) |-> $past(bus_in.wr, 2))
        else $error("output enable moved without a write");
endmodule : cac_counter_array_monitor

bind cac_counter_array cac_counter_array_monitor #(.NUM_MOD(NUM_MOD)) i_cac_counter_array_monitor (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .global_irq_enable_in(global_irq_enable_in),
    .array_irq_enable_in(array_irq_enable_in),
    .irq_out(irq_out),
    .module_pin_in(module_pin_in),
    .module_pin_out(module_pin_out),
    .module_pin_oe_out(module_pin_oe_out)
);
`default_nettype wire

/* File: tb/cac_pin_model.sv */
`default_nettype none
module cac_pin_model
    import cac_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Pin levels and drive
    input wire logic [CAC_NUM_MOD-1:0] level_cmd_in,
    input wire logic [CAC_NUM_MOD-1:0] pin_out_in,
    input wire logic [CAC_NUM_MOD-1:0] pin_oe_in,
    output logic [CAC_NUM_MOD-1:0] pin_level_out,
    // Count sources
    output logic ext_count_out,
    output logic ext_osc_out,
    output logic timer0_ovf_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r = 4'h0;
    logic [CAC_NUM_MOD-1:0] lvl_r = '0;
    logic eci_r = 1'b1;
    logic osc_r = 1'b0;
    logic t0_r = 1'b0;
    always_ff @(posedge clk_in) begin
        cnt_r <= (cnt_r == 4'hb) ? 4'h0 : cnt_r + 4'h1;
        t0_r <= (cnt_r == 4'hb);
    end
    always_ff @(posedge clk_in) begin
        if (cnt_r[0]) lvl_r <= level_cmd_in;
    end
    always_ff @(posedge clk_in) begin
        if (cnt_r[1:0] == 2'h3) eci_r <= ~eci_r;
    end
    // Oscillator runs free, period of 6 clocks
    always_ff @(posedge clk_in) begin
        if (cnt_r == 4'h2 || cnt_r == 4'h5 || cnt_r == 4'h8 || cnt_r == 4'hb)
            osc_r <= ~osc_r;
    end
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & lvl_r);
    assign ext_count_out = eci_r;
    assign ext_osc_out = osc_r;
    assign timer0_ovf_out = t0_r;
endmodule : cac_pin_model
`default_nettype wire

/* File: tb/test_counter_array_capture_compare.sv */
`default_nettype none
module test_counter_array_capture_compare;
    timeunit 1ns;
    timeprecision 1ns;
    import cac_pkg::*;
    logic clk_in, rst_n_in, ge, ae, idle, t0, ecnt, osc, irq;
    cac_bus_req_type bus_in;
    logic [7:0] rdata_out;
    logic [2:0] pin_cmd, pin_in, pin_out, pin_oe;
    int n_fail = 0;
    int samples_checked = 0;

    cac_counter_array i_cac_counter_array (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .bus_in(bus_in), .rdata_out(rdata_out), .global_irq_enable_in(ge),
        .array_irq_enable_in(ae), .cpu_idle_in(idle), .timer0_ovf_in(t0),
        .ext_count_input_in(ecnt), .ext_osc_in(osc), .module_pin_in(pin_in),
        .module_pin_out(pin_out), .module_pin_oe_out(pin_oe), .irq_out(irq));
    cac_pin_model i_cac_pin_model (.clk_in(clk_in), .level_cmd_in(pin_cmd),
        .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pin_level_out(pin_in),
        .ext_count_out(ecnt), .ext_osc_out(osc), .timer0_ovf_out(t0));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_rng(input logic [15:0] got, input int lo, input int hi);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_fail++;
            $display("[ERR] %0t got %0d want %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_rng
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in) bus_in <= {1'b1, 1'b0, a, d};
        @(posedge clk_in) bus_in <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in) bus_in <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in) bus_in <= '0;
        #1 d = rdata_out;
    endtask : rd
    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        cmp_val({8'h00, d & m}, {8'h00, e});
    endtask : rc
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic set_cnt(input logic [15:0] v);
        wr(CAC_ADDR_CTRL, 8'h00);
        wr(CAC_ADDR_CNT_LO, v[7:0]);
        wr(CAC_ADDR_CNT_HI, v[15:8]);
    endtask : set_cnt
    task automatic toggles(input int cyc, output int n);
        logic p;
        n = 0;
        p = pin_out[1];
        repeat (cyc) begin
            tick(1);
            if (pin_out[1] !== p) n++;
            p = pin_out[1];
        end
    endtask : toggles
    task automatic do_reset;
        @(posedge clk_in) rst_n_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rc(CAC_ADDR_MODE, 8'hff, CAC_MODE_RST);
        rc(4'hb, 8'hff, 8'h00);
        wr(CAC_ADDR_MMODE0 + 4'h2, 8'h31);
        rc(CAC_ADDR_MMODE0 + 4'h2, 8'hff, 8'h00);
        wr(CAC_ADDR_MODE, 8'h0e);
        rc(CAC_ADDR_MODE, 8'hff, 8'h00);
        $display("reset test done");
    endtask : do_reset
    function automatic int tb_div(input int k);
        int t[6] = '{12, 4, 12, 8, 1, 48};
        return t[k];
    endfunction : tb_div

    initial begin
        logic [7:0] d;
        logic [15:0] r;
        int n;
        rst_n_in = 1'b0;
        bus_in = '0;
        ge = 1'b1;
        ae = 1'b1;
        idle = 1'b0;
        pin_cmd = 3'h0;
        n = $urandom(49);
        do_reset();
        for (int k = 0; k < 6; k++) begin
            set_cnt(16'h0000);
            idle <= k[0];
            wr(CAC_ADDR_MODE, {4'h0, 3'(k), 1'b0});
            wr(CAC_ADDR_CTRL, 8'h40);
            tick(240);
            wr(CAC_ADDR_CTRL, 8'h00);
            rd(CAC_ADDR_CNT_LO, d);
            cmp_rng({8'h00, d}, 242 / tb_div(k) - 2, 242 / tb_div(k) + 2);
        end
        $display("timebase test done");
        set_cnt(16'hfff0);
        wr(CAC_ADDR_MODE, 8'h09);
        wr(CAC_ADDR_CTRL, 8'h40);
        tick(20);
        rc(CAC_ADDR_CTRL, 8'h80, 8'h80);
        cmp_val({15'h0, irq}, 16'h1);
        @(posedge clk_in) ge <= 1'b0;
        tick(3);
        cmp_val({15'h0, irq}, 16'h0);
        @(posedge clk_in) ge <= 1'b1;
        rc(CAC_ADDR_CTRL, 8'h80, 8'h80);
        wr(CAC_ADDR_CTRL, 8'h40);
        rc(CAC_ADDR_CTRL, 8'h80, 8'h00);
        set_cnt(16'h01f8);
        wr(CAC_ADDR_CTRL, 8'h40);
        rd(CAC_ADDR_CNT_LO, d);
        cmp_rng({8'h00, d}, 16'hf6, 16'hfe);
        tick(8);
        rc(CAC_ADDR_CNT_HI, 8'hff, 8'h01);
        wr(CAC_ADDR_MODE, 8'h89);
        rd(CAC_ADDR_CNT_LO, d);
        tick(20);
        rc(CAC_ADDR_CNT_LO, 8'hff, d);
        @(posedge clk_in) idle <= 1'b0;
        rd(CAC_ADDR_CNT_LO, r[7:0]);
        cmp_rng({8'h00, r[7:0] - d}, 1, 3);
        wr(CAC_ADDR_MODE, 8'h09);
        $display("overflow test done");
        r = 16'($urandom);
        set_cnt(r);
        for (int k = 1; k < 4; k++) begin
            wr(CAC_ADDR_MMODE0, {2'b00, 2'(k), 4'h1});
            wr(CAC_ADDR_CTRL, 8'h00);
            @(posedge clk_in) pin_cmd[0] <= 1'b1;
            tick(8);
            rc(CAC_ADDR_CTRL, 8'h01, {7'h0, k[1]});
            wr(CAC_ADDR_CTRL, 8'h00);
            @(posedge clk_in) pin_cmd[0] <= 1'b0;
            tick(8);
            rc(CAC_ADDR_CTRL, 8'h01, {7'h0, k[0]});
        end
        rc(CAC_ADDR_CMP_LO0, 8'hff, r[7:0]);
        rc(CAC_ADDR_CMP_HI0, 8'hff, r[15:8]);
        rc(CAC_ADDR_PINS, 8'h01, 8'h00);
        cmp_val({15'h0, irq}, 16'h1);
        wr(CAC_ADDR_MMODE0, 8'h30);
        tick(2);
        cmp_val({15'h0, irq}, 16'h0);
        $display("capture test done");
        set_cnt(16'h0100);
        wr(CAC_ADDR_MMODE0 + 4'h1, 8'h49);
        wr(CAC_ADDR_CMP_LO0 + 4'h1, 8'h20);
        rc(CAC_ADDR_MMODE0 + 4'h1, 8'h40, 8'h00);
        wr(CAC_ADDR_CMP_HI0 + 4'h1, 8'h01);
        rc(CAC_ADDR_MMODE0 + 4'h1, 8'h40, 8'h40);
        wr(CAC_ADDR_MMODE0, 8'h4c);
        wr(CAC_ADDR_CMP_LO0, 8'h40);
        wr(CAC_ADDR_CMP_HI0, 8'h01);
        wr(CAC_ADDR_CTRL, 8'h40);
        tick(16);
        rc(CAC_ADDR_CTRL, 8'h02, 8'h00);
        tick(24);
        rc(CAC_ADDR_CTRL, 8'h02, 8'h02);
        cmp_val({15'h0, pin_out[0]}, 16'h0);
        tick(32);
        cmp_val({14'h0, pin_oe[0], pin_out[0]}, 16'h3);
        tick(40);
        cmp_val({15'h0, pin_out[0]}, 16'h1);
        $display("compare test done");
        for (int k = 0; k < 2; k++) begin
            set_cnt(16'h0000);
            wr(CAC_ADDR_MMODE0 + 4'h1, 8'h46);
            wr(CAC_ADDR_CMP_LO0 + 4'h1, 8'h10);
            wr(CAC_ADDR_CMP_HI0 + 4'h1, k ? 8'h00 : 8'h08);
            wr(CAC_ADDR_CTRL, 8'h40);
            toggles(k ? 260 : 160, n);
            cmp_rng(16'(n), k ? 1 : 18, k ? 1 : 20);
        end
        $display("frequency test done");
        do_reset();
        report_and_stop();
    end

    initial begin
        repeat (30000) @(posedge clk_in);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : test_counter_array_capture_compare
`default_nettype wire
